// >>> dtwbsp_pkg.sv
// Shared constants and carrier types for the two-word burst memory port.
package dtwbsp_pkg;

  localparam int WORD_W         = 18;
  localparam int LANE_W         = 9;
  localparam int BW_W           = WORD_W / LANE_W;
  localparam int ADDR_W         = 8;
  localparam int LOG_FIFO_DEPTH = 8;
  localparam int SYNC_STAGES    = 2;

  // Read latencies in half cycles of the main input clock.
  localparam int LAT_LONG_HALF  = 5;
  localparam int LAT_SHORT_HALF = 2;

  // Highest rated main input clock, kept by the controller.
  localparam int MAX_LINK_MHZ   = 450;
  localparam int CORE_CLK_MHZ   = 25;

  // Address bus phase: the first rising edge after reset carries a read.
  localparam logic PHASE_RD     = 1'b0;
  localparam logic PHASE_WR     = 1'b1;
  localparam logic PHASE_RST    = PHASE_RD;

  typedef struct packed {
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w0;
  } dtwbsp_burst_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w0;
    logic [BW_W-1:0]   bws1_b;
    logic [BW_W-1:0]   bws0_b;
  } dtwbsp_wr_s;

  localparam int LOG_W = $bits(dtwbsp_wr_s);

  typedef enum logic [1:0] {
    DTWBSP_HS_IDLE = 2'b01,
    DTWBSP_HS_WAIT = 2'b10
  } dtwbsp_hs_e;

endpackage : dtwbsp_pkg

// >>> dtwbsp_sync.sv
// Two-flop level synchroniser, one per bit.
`timescale 1ns/1ps
module dtwbsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // Destination clock.
  input  wire logic         rst_b_i, // Asynchronous reset, active low.
  input  wire logic [W-1:0] d_i,     // Level from another domain.
  output logic      [W-1:0] q_o      // Synchronised level.
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb
  begin
    meta_next = d_i;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : dtwbsp_sync

// >>> dtwbsp_fifo.sv
// Single-clock FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module dtwbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,       // Clock.
  input  wire logic             rst_b_i,     // Asynchronous reset, low.
  input  wire logic             in_valid_i,  // Word offered.
  output logic                  in_ready_o,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data_i,   // Word to store.
  output logic                  out_valid_o, // Word available.
  input  wire logic             out_ready_i, // Drain takes the word.
  output logic      [WIDTH-1:0] out_data_o   // Oldest word.
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != FULL);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
    begin
      wr_ptr_next = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage carries no reset; only the pointers and the count decide what is valid.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

endmodule : dtwbsp_fifo

// >>> dtwbsp_top.sv
// Two-word burst static memory port with DDR read and write data paths.
//
// Behaviour
// - Read and write addresses alternate on rising edges.
// - Each location holds two words of one width.
// - Data moves on rising edges of both clocks.
// - Long mode returns data two and a half cycles later.
// - Short mode returns data one cycle later.
// - All synchronous inputs land in input registers.
// - Read data leaves through clocked output registers.
// - Writes finish self-timed, no extra strobes needed.
// - Reads and writes proceed independently and concurrently.
// - Each port has its own select.
// - Complementary echo clocks accompany read data.
// - Valid output marks read data on outputs.
// - Only rising edges of the pair act.
// - Reads always see the newest written data.
`timescale 1ns/1ps
module dtwbsp_top #(
  parameter int FIFO_DEPTH = dtwbsp_pkg::LOG_FIFO_DEPTH
) (
  input  wire logic                          clock_i,      // Core clock.
  input  wire logic                          rst_b_i,      // Reset, low.
  input  wire logic                          link_clk_i,   // Main input clk.
  input  wire logic                          pll_disable_i,// High: long lat.
  input  wire logic [dtwbsp_pkg::ADDR_W-1:0] addr_i,       // Shared address.
  input  wire logic                          rd_sel_b_i,   // Read select.
  input  wire logic                          wr_sel_b_i,   // Write select.
  input  wire logic [dtwbsp_pkg::WORD_W-1:0] wr_data_i,    // Write data.
  input  wire logic [dtwbsp_pkg::BW_W-1:0]   byte_write_select_b_i, // Lanes.
  output logic      [dtwbsp_pkg::WORD_W-1:0] rd_data_o,    // Read data.
  output logic                               read_data_valid_o, // Valid.
  output logic                               echo_clock_o,   // Echo clock.
  output logic                               echo_clock_b_o, // Its inverse.
  output logic                               write_stall_o,  // Log full.
  output logic                               log_valid_o,  // Write record.
  output dtwbsp_pkg::dtwbsp_wr_s             log_data_o,   // Record body.
  input  wire logic                          log_ready_i   // Record taken.
);

  localparam int AW = dtwbsp_pkg::ADDR_W;
  localparam int WW = dtwbsp_pkg::WORD_W;
  localparam int LW = dtwbsp_pkg::LANE_W;
  localparam int BW = dtwbsp_pkg::BW_W;

  // Link reset: asserts at once, releases on a link clock edge.
  logic lrst_meta_reg;
  logic lrst_b;

  always_ff @(posedge link_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lrst_meta_reg <= 1'b0;
      lrst_b        <= 1'b0;
    end
    else
    begin
      lrst_meta_reg <= 1'b1;
      lrst_b        <= lrst_meta_reg;
    end
  end

  logic lat_long;

  dtwbsp_sync #(.W(1)) u_pll_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (lrst_b),
    .d_i     (pll_disable_i),
    .q_o     (lat_long)
  );

  // Memory array, word 1 above word 0 at each location.
  dtwbsp_pkg::dtwbsp_burst_s mem [2**AW];

  // Input registers on the rising edge of the main clock.
  logic                         phase_reg;
  logic                         phase_next;
  logic                         rd_pend_reg;
  logic                         rd_pend_next;
  logic [AW-1:0]                rd_addr_reg;
  logic [AW-1:0]                rd_addr_next;
  logic                         wr_pend_reg;
  logic                         wr_pend_next;
  logic [AW-1:0]                wr_addr_reg;
  logic [AW-1:0]                wr_addr_next;
  logic [WW-1:0]                wr_w0_reg;
  logic [WW-1:0]                wr_w0_next;
  logic [BW-1:0]                wr_b0_reg;
  logic [BW-1:0]                wr_b0_next;
  // Second beat arrives on the rising edge of the complement clock.
  logic [WW-1:0]                wr_w1_reg;
  logic [BW-1:0]                wr_b1_reg;

  logic                         fifo_in_ready;
  logic                         commit;
  dtwbsp_pkg::dtwbsp_burst_s    old_word;
  dtwbsp_pkg::dtwbsp_burst_s    merged;
  dtwbsp_pkg::dtwbsp_wr_s       wr_rec;

  always_comb
  begin
    phase_next   = ~phase_reg;
    rd_pend_next = (phase_reg == dtwbsp_pkg::PHASE_RD) && !rd_sel_b_i;
    rd_addr_next = rd_pend_next ? addr_i : rd_addr_reg;
    wr_pend_next = (phase_reg == dtwbsp_pkg::PHASE_WR) && !wr_sel_b_i;
    wr_addr_next = wr_pend_next ? addr_i : wr_addr_reg;
    wr_w0_next   = wr_pend_next ? wr_data_i : wr_w0_reg;
    wr_b0_next   = wr_pend_next ? byte_write_select_b_i : wr_b0_reg;
  end

  always_ff @(posedge link_clk_i or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      phase_reg   <= dtwbsp_pkg::PHASE_RST;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_w0_reg   <= '0;
      wr_b0_reg   <= '1;
    end
    else
    begin
      phase_reg   <= phase_next;
      rd_pend_reg <= rd_pend_next;
      rd_addr_reg <= rd_addr_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      wr_w0_reg   <= wr_w0_next;
      wr_b0_reg   <= wr_b0_next;
    end
  end

  // The falling edge of the main clock stands for the complement's rise.
  always_ff @(negedge link_clk_i or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      wr_w1_reg <= '0;
      wr_b1_reg <= '1;
    end
    else if (wr_pend_reg)
    begin
      wr_w1_reg <= wr_data_i;
      wr_b1_reg <= byte_write_select_b_i;
    end
  end

  // Byte lane merge: a low select writes the lane, a high one keeps it.
  assign old_word = mem[wr_addr_reg];
  for (genvar g = 0; g < BW; g++)
  begin : g_lane
    assign merged.w0[g*LW +: LW] = wr_b0_reg[g] ? old_word.w0[g*LW +: LW]
                                                : wr_w0_reg[g*LW +: LW];
    assign merged.w1[g*LW +: LW] = wr_b1_reg[g] ? old_word.w1[g*LW +: LW]
                                                : wr_w1_reg[g*LW +: LW];
  end

  // A write lands one edge after its address, with no wait states.
  // Refused when the record log is full, so the log never loses one.
  assign commit = wr_pend_reg && fifo_in_ready;

  always_ff @(posedge link_clk_i)
  begin
    if (commit)
    begin
      mem[wr_addr_reg] <= merged;
    end
  end

  assign wr_rec.addr   = wr_addr_reg;
  assign wr_rec.w1     = wr_w1_reg;
  assign wr_rec.w0     = wr_w0_reg;
  assign wr_rec.bws1_b = wr_b1_reg;
  assign wr_rec.bws0_b = wr_b0_reg;

  // Read pipeline. The array is read one edge after the address, which
  // is after any earlier write has landed, so reads stay coherent.
  dtwbsp_pkg::dtwbsp_burst_s s1_data_reg;
  dtwbsp_pkg::dtwbsp_burst_s s1_data_next;
  dtwbsp_pkg::dtwbsp_burst_s s2_data_reg;
  dtwbsp_pkg::dtwbsp_burst_s s2_data_next;
  logic                      s1_valid_reg;
  logic                      s1_valid_next;
  logic                      s2_valid_reg;
  logic                      s2_valid_next;
  logic [WW-1:0]             pos_data_reg;
  logic [WW-1:0]             pos_data_next;
  logic                      pos_valid_reg;
  logic                      pos_valid_next;
  logic                      echo_pos_reg;
  logic                      stall_reg;

  always_comb
  begin
    s1_valid_next = rd_pend_reg;
    s1_data_next  = rd_pend_reg ? mem[rd_addr_reg] : s1_data_reg;
    s2_valid_next = s1_valid_reg;
    s2_data_next  = s1_data_reg;
    if (lat_long)
    begin
      pos_valid_next = s2_valid_reg;
      pos_data_next  = s2_data_reg.w1;
    end
    else
    begin
      pos_valid_next = rd_pend_reg;
      pos_data_next  = mem[rd_addr_reg].w0;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      s1_valid_reg  <= 1'b0;
      s1_data_reg   <= '0;
      s2_valid_reg  <= 1'b0;
      s2_data_reg   <= '0;
      pos_valid_reg <= 1'b0;
      pos_data_reg  <= '0;
      echo_pos_reg  <= 1'b0;
      stall_reg     <= 1'b0;
    end
    else
    begin
      s1_valid_reg  <= s1_valid_next;
      s1_data_reg   <= s1_data_next;
      s2_valid_reg  <= s2_valid_next;
      s2_data_reg   <= s2_data_next;
      pos_valid_reg <= pos_valid_next;
      pos_data_reg  <= pos_data_next;
      echo_pos_reg  <= ~echo_pos_reg;
      stall_reg     <= ~fifo_in_ready;
    end
  end

  // Half-cycle launch registers on the complement's rising edge.
  logic [WW-1:0] neg_data_reg;
  logic          neg_valid_reg;
  logic          echo_neg_reg;

  always_ff @(negedge link_clk_i or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      neg_data_reg  <= '0;
      neg_valid_reg <= 1'b0;
      echo_neg_reg  <= 1'b0;
    end
    else
    begin
      neg_valid_reg <= s1_valid_reg && !lat_long || s2_valid_reg && lat_long;
      neg_data_reg  <= lat_long ? s2_data_reg.w0 : s1_data_reg.w1;
      echo_neg_reg  <= echo_pos_reg;
    end
  end

  // High from a rising edge of the main clock to the next falling one.
  // Built from two flops so that the select never glitches.
  logic half_hi;

  assign half_hi           = echo_pos_reg ^ echo_neg_reg;
  assign echo_clock_o      = half_hi;
  assign echo_clock_b_o    = ~half_hi;
  assign rd_data_o         = half_hi ? pos_data_reg : neg_data_reg;
  assign read_data_valid_o = half_hi ? pos_valid_reg : neg_valid_reg;
  assign write_stall_o     = stall_reg;

  // Write record log, drained toward the core clock by a handshake.
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  dtwbsp_pkg::dtwbsp_wr_s fifo_out_data;

  dtwbsp_fifo #(
    .WIDTH (dtwbsp_pkg::LOG_W),
    .DEPTH (FIFO_DEPTH)
  ) u_log_fifo (
    .clk_i       (link_clk_i),
    .rst_b_i     (lrst_b),
    .in_valid_i  (wr_pend_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (wr_rec),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  dtwbsp_pkg::dtwbsp_hs_e hs_reg;
  dtwbsp_pkg::dtwbsp_hs_e hs_next;
  dtwbsp_pkg::dtwbsp_wr_s hold_reg;
  dtwbsp_pkg::dtwbsp_wr_s hold_next;
  logic                   req_reg;
  logic                   req_next;
  logic                   ack_sync;

  assign fifo_out_ready = (hs_reg == dtwbsp_pkg::DTWBSP_HS_IDLE);

  always_comb
  begin
    hs_next   = hs_reg;
    hold_next = hold_reg;
    req_next  = req_reg;
    case (hs_reg)
      dtwbsp_pkg::DTWBSP_HS_IDLE:
      begin
        if (fifo_out_valid)
        begin
          hold_next = fifo_out_data;
          req_next  = ~req_reg;
          hs_next   = dtwbsp_pkg::DTWBSP_HS_WAIT;
        end
      end
      dtwbsp_pkg::DTWBSP_HS_WAIT:
      begin
        if (ack_sync == req_reg)
        begin
          hs_next = dtwbsp_pkg::DTWBSP_HS_IDLE;
        end
      end
      default:
      begin
        hs_next = dtwbsp_pkg::DTWBSP_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_i or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      hs_reg   <= dtwbsp_pkg::DTWBSP_HS_IDLE;
      hold_reg <= '0;
      req_reg  <= 1'b0;
    end
    else
    begin
      hs_reg   <= hs_next;
      hold_reg <= hold_next;
      req_reg  <= req_next;
    end
  end

  // Core side: the held record is stable while the request is open.
  logic                   req_sync;
  logic                   seen_reg;
  logic                   seen_next;
  logic                   ack_reg;
  logic                   ack_next;
  logic                   lv_reg;
  logic                   lv_next;
  dtwbsp_pkg::dtwbsp_wr_s ld_reg;
  dtwbsp_pkg::dtwbsp_wr_s ld_next;

  dtwbsp_sync #(.W(1)) u_req_sync (
    .clk_i   (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     (req_reg),
    .q_o     (req_sync)
  );

  dtwbsp_sync #(.W(1)) u_ack_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (lrst_b),
    .d_i     (ack_reg),
    .q_o     (ack_sync)
  );

  always_comb
  begin
    seen_next = seen_reg;
    ack_next  = ack_reg;
    lv_next   = lv_reg;
    ld_next   = ld_reg;
    if (lv_reg && log_ready_i)
    begin
      lv_next  = 1'b0;
      ack_next = seen_reg;
    end
    else if (!lv_reg && (req_sync != seen_reg))
    begin
      lv_next   = 1'b1;
      ld_next   = hold_reg;
      seen_next = req_sync;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seen_reg <= 1'b0;
      ack_reg  <= 1'b0;
      lv_reg   <= 1'b0;
      ld_reg   <= '0;
    end
    else
    begin
      seen_reg <= seen_next;
      ack_reg  <= ack_next;
      lv_reg   <= lv_next;
      ld_reg   <= ld_next;
    end
  end

  assign log_valid_o = lv_reg;
  assign log_data_o  = ld_reg;

  // Checks on the link clock.
  sequence s_long_path;
    s1_valid_reg ##1 s2_valid_reg ##1 pos_valid_reg;
  endsequence

  property p_lat_long_seq;
    @(posedge link_clk_i) disable iff (!lrst_b)
    rd_pend_reg && lat_long && $stable(lat_long) |=> s_long_path;
  endproperty
  a_lat_long_seq: assert property (p_lat_long_seq)
    else $error("long latency read not returned on time");

  property p_lat_short;
    @(posedge link_clk_i) disable iff (!lrst_b)
    rd_pend_reg && !lat_long |=> pos_valid_reg;
  endproperty
  a_lat_short: assert property (p_lat_short)
    else $error("short latency read not returned after one cycle");

  property p_phase;
    @(posedge link_clk_i) disable iff (!lrst_b)
    $past(lrst_b) |-> phase_reg != $past(phase_reg);
  endproperty
  a_phase: assert property (p_phase)
    else $error("address phase did not alternate");

  property p_sel;
    @(posedge link_clk_i) disable iff (!lrst_b)
    rd_pend_reg |-> (phase_reg == dtwbsp_pkg::PHASE_WR) && !wr_pend_reg;
  endproperty
  a_sel: assert property (p_sel)
    else $error("read and write captured on the wrong phase");

  property p_commit;
    @(posedge link_clk_i) disable iff (!lrst_b)
    commit |=> mem[$past(wr_addr_reg)] == $past(merged);
  endproperty
  a_commit: assert property (p_commit)
    else $error("write did not land one edge after its address");

  property p_lane_keep;
    @(posedge link_clk_i) disable iff (!lrst_b)
    commit && (&wr_b0_reg) |=>
      mem[$past(wr_addr_reg)].w0 == $past(old_word.w0);
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("masked lanes were overwritten");

  property p_echo;
    @(posedge link_clk_i) disable iff (!lrst_b)
    $past(lrst_b) |-> (echo_pos_reg != $past(echo_pos_reg)) && !half_hi;
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo clock not low before a rising edge");

  property p_valid;
    @(posedge link_clk_i) disable iff (!lrst_b)
    pos_valid_reg && $past(lat_long) |-> $past(s2_valid_reg);
  endproperty
  a_valid: assert property (p_valid)
    else $error("read valid raised without a read in flight");

  property p_stall;
    @(posedge link_clk_i) disable iff (!lrst_b)
    !fifo_in_ready |=> write_stall_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("write stall not shown while the log is full");

endmodule : dtwbsp_top

// >>> dtwbsp_ctl.sv
// Behavioural memory controller driving the link side of the port.
`timescale 1ns/1ps
module dtwbsp_ctl (
  input  wire logic        rst_b_i,    // Reset, low.
  input  wire logic [17:0] rd_data_i,  // Read word.
  input  wire logic        vld_i,      // Word valid.
  output logic             lclk_o,     // Input clock.
  output logic      [7:0]  addr_o,     // Address.
  output logic             rd_sel_b_o, // Read select.
  output logic             wr_sel_b_o, // Write select.
  output logic      [17:0] wd_o,       // Write data.
  output logic      [1:0]  bws_b_o     // Lane selects.
);
  int n;

  initial
  begin
    lclk_o = 1'b0;
    {addr_o, rd_sel_b_o, wr_sel_b_o, wd_o, bws_b_o} = '1;
    #1.7;
    forever #3 lclk_o = ~lclk_o;
  end

  always @(posedge lclk_o or negedge rst_b_i)
    if (!rst_b_i)
      n <= 0;
    else
      n <= n + 1;

  // Stops at the edge that launches a request for the wanted phase.
  task automatic to_phase(input int odd);
    do @(posedge lclk_o); while (n < 2 - odd || n % 2 != odd);
  endtask : to_phase

  task automatic wr(input logic [7:0] a, input logic [35:0] d,
                    input logic [3:0] bw);
    to_phase(0);
    addr_o <= a;
    wr_sel_b_o <= 1'b0;
    wd_o <= d[17:0];
    bws_b_o <= bw[1:0];
    @(posedge lclk_o);
    wr_sel_b_o <= 1'b1;
    wd_o <= d[35:18];
    bws_b_o <= bw[3:2];
    // Released lines carry junk so a late sample cannot look right.
    @(negedge lclk_o);
    wd_o <= ~d[35:18];
    bws_b_o <= ~bw[3:2];
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [35:0] r,
                    output int lat, output int nv);
    lat = 0;
    nv = 0;
    r = '0;
    to_phase(1);
    addr_o <= a;
    rd_sel_b_o <= 1'b0;
    @(posedge lclk_o);
    rd_sel_b_o <= 1'b1;
    // Sampled before the port updates: each shows the half just ended.
    for (int h = 1; h <= 8; h++)
    begin
      @(lclk_o);
      if (vld_i === 1'b1)
      begin
        if (nv == 0)
          lat = h;
        r = {rd_data_i, r[35:18]};
        nv++;
      end
    end
  endtask : rd
endmodule : dtwbsp_ctl

// >>> ddr_two_word_burst_sram_port_test.sv
// Self-checking bench for the two-word burst memory port.
`timescale 1ns/1ps
module ddr_two_word_burst_sram_port_test;
  logic                      clock_i, rst_b_i, pll, log_ready, hold;
  logic                      echo_on, lclk, rd_sel_b, wr_sel_b, vld;
  logic                      echo, echo_b, stall, log_valid;
  logic [7:0]                addr;
  logic [17:0]               wd, rdat;
  logic [1:0]                bws_b;
  dtwbsp_pkg::dtwbsp_wr_s    log_data;
  dtwbsp_pkg::dtwbsp_burst_s mem [256];
  logic [47:0]               logq [$];
  logic [31:0]               seed = 32'h00010c42;
  int                        n_mismatch, n_checks, cyc;

  dtwbsp_top dut_u (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .link_clk_i(lclk),
    .pll_disable_i(pll), .addr_i(addr), .rd_sel_b_i(rd_sel_b),
    .wr_sel_b_i(wr_sel_b), .wr_data_i(wd), .byte_write_select_b_i(bws_b),
    .rd_data_o(rdat), .read_data_valid_o(vld), .echo_clock_o(echo),
    .echo_clock_b_o(echo_b), .write_stall_o(stall),
    .log_valid_o(log_valid), .log_data_o(log_data), .log_ready_i(log_ready)
  );

  dtwbsp_ctl ctl_u (
    .rst_b_i(rst_b_i), .rd_data_i(rdat), .vld_i(vld), .lclk_o(lclk),
    .addr_o(addr), .rd_sel_b_o(rd_sel_b), .wr_sel_b_o(wr_sel_b),
    .wd_o(wd), .bws_b_o(bws_b)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [17:0] merge(input logic [17:0] o, nw,
                                        input logic [1:0] b);
    merge = o;
    for (int l = 0; l < 2; l++)
      if (!b[l])
        merge[l*9 +: 9] = nw[l*9 +: 9];
  endfunction : merge

  task automatic check(input logic [71:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic put(input logic [7:0] a, input logic [35:0] d,
                     input logic [3:0] bw);
    ctl_u.wr(a, d, bw);
    mem[a].w0 = merge(mem[a].w0, d[17:0], bw[1:0]);
    mem[a].w1 = merge(mem[a].w1, d[35:18], bw[3:2]);
    logq.push_back({a, d, bw});
  endtask : put

  task automatic get(input logic [7:0] a);
    logic [35:0] r;
    int          lat, nv;
    ctl_u.rd(a, r, lat, nv);
    check(r, mem[a], "read data");
    check(lat, (pll ? dtwbsp_pkg::LAT_LONG_HALF
                    : dtwbsp_pkg::LAT_SHORT_HALF) + 1, "latency");
    check(nv, 2, "valid count");
  endtask : get

  task automatic drain();
    repeat (400) if (logq.size() != 0) @(posedge clock_i);
  endtask : drain

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Ready is kept off the random stream so its draws stay repeatable.
  always @(posedge clock_i)
  begin
    cyc++;
    if (log_valid === 1'b1 && log_ready === 1'b1)
      check(log_data, logq.pop_front(), "log record");
    log_ready <= !hold && cyc % 3 != 0;
    if (cyc == 5000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  always @(lclk)
    if (echo_on)
      check({echo, echo_b}, {~lclk, lclk}, "echo clocks");

  initial
  begin
    rst_b_i = 1'b0;
    pll = 1'b1;
    log_ready = 1'b0;
    hold = 1'b0;
    echo_on = 1'b0;
    repeat (8) @(posedge clock_i);
    check({rdat, vld, echo, echo_b, stall, log_valid, log_data},
          {18'h0, 4'h2, 49'h0}, "reset values");
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    echo_on <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      if (i == 12)
      begin
        @(posedge clock_i);
        pll <= 1'b0;
        repeat (4) @(posedge clock_i);
      end
      put(8'(rnd()), {18'(rnd()), 18'(rnd())}, 4'h0);
      get(logq[$][47:40]);
      drain();
    end
    $display("test bursts in both latency modes done");
    for (int b = 0; b < 16; b++)
    begin
      put(8'h5a, {18'(rnd()), 18'(rnd())}, 4'(b));
      get(8'h5a);
      drain();
    end
    $display("test lane selects done");
    ctl_u.to_phase(1);
    fork
      put(8'h5a, {18'h3ffff, 18'h0}, 4'h0);
      begin
        @(posedge lclk);
        get(8'h5a);
      end
    join
    drain();
    $display("test read at commit edge done");
    @(posedge clock_i);
    hold <= 1'b1;
    repeat (2) @(posedge clock_i);
    // One record waits in the handshake, eight more fill the log.
    for (int i = 0; i < 9; i++)
      put(8'(i), {18'(rnd()), 18'(rnd())}, 4'h0);
    ctl_u.wr(8'h5a, 36'h0, 4'h0);
    repeat (4) @(posedge lclk);
    check(stall, 1'b1, "stall while log full");
    get(8'h5a);
    @(posedge clock_i);
    hold <= 1'b0;
    drain();
    repeat (4) @(posedge clock_i);
    check(logq.size(), 0, "records left");
    check(stall, 1'b0, "stall after drain");
    $display("test full log done");
    report_and_stop();
  end
endmodule : ddr_two_word_burst_sram_port_test
